// File: pkg/mode_cfg_pkg.sv
// Purpose: shared constants and types of the static mode configuration block
// Assumes: pclk at 200 MHz, 32-bit APB with byte addresses
// Notes: long cycle counts are only defaults; top module parameters can override them
package mode_cfg_pkg;

	// ----------------------------------------------------------------
	// clock and times
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned RELEASE_SHORT_US = 1;
	localparam int unsigned RELEASE_LONG_MS = 1;
	localparam int unsigned TICK_SHORT_MS = 1;
	localparam int unsigned TICK_LONG_MS = 10;
	// least times round up to whole cycles
	localparam int unsigned RELEASE_SHORT_CYC =
		(RELEASE_SHORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RELEASE_LONG_CYC =
		(RELEASE_LONG_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// cycles per millisecond first, so the 10 ms product stays in 32 bits
	localparam int unsigned CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;
	localparam int unsigned TICK_SHORT_CYC = TICK_SHORT_MS * CYC_PER_MS;
	localparam int unsigned TICK_LONG_CYC = TICK_LONG_MS * CYC_PER_MS;
	localparam int CNT_W = 21;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_WD_LIMIT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_WD_COUNT = 8'h18;

	// mode register field positions
	localparam int POS_POL = 4;
	localparam int POS_EARLY = 5;
	localparam int POS_SYNC = 6;
	localparam int POS_FREEZE = 7;
	localparam int POS_PROTO = 8;
	localparam int POS_REL_TB = 9;
	localparam int POS_TICK_TB = 10;
	localparam int POS_WATCHDOG_TEST_SELECT = 11;
	localparam logic [15:0] MODE_RESET = 16'h0000;

	// control register (write one to act)
	localparam int POS_START = 0;
	localparam int POS_RELEASE = 1;
	localparam int POS_GO_OFFLINE = 2;
	localparam int POS_WD_KICK = 3;

	// event / mask register
	localparam int EVT_N = 3;
	localparam int EVT_TICK = 0;
	localparam int EVT_WD = 1;
	localparam int EVT_EXT = 2;
	localparam logic [EVT_N-1:0] MASK_RESET = 3'h0;
	localparam logic [15:0] WD_LIMIT_RESET = 16'hFFFF;

	typedef struct packed {
		logic watchdog_test_select;
		logic tick_timebase;
		logic interrupt_release_timebase;
		logic cyclic_slave_protocol_enable;
		logic freeze_supported;
		logic sync_supported;
		logic early_ready;
		logic interrupt_polarity_select;
	} mode_cfg_s;

	typedef enum logic [1:0] {
		ST_OFFLINE = 2'b01,
		ST_ONLINE = 2'b10
	} link_state_e;

endpackage : mode_cfg_pkg

// File: hdl/tick_divider.sv
// Purpose: periodic one-cycle tick with two selectable periods
// Assumes: period counts at least 2
// Notes: a change of selection takes effect at once; a count already past the new top wraps on the next cycle
`timescale 1ns/1ps
module tick_divider #(
	parameter int unsigned SHORT_CYC = 200000,
	parameter int unsigned LONG_CYC = 2000000
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic long_sel,
	// result
	output logic tick
);
	import mode_cfg_pkg::*;

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] top;

	assign top = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r >= top) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule : tick_divider

// File: hdl/inactive_hold.sv
// Purpose: holds a busy level for a selectable least number of cycles
// Assumes: start is a one-cycle pulse on pclk
// Notes: a new start restarts the full hold
`timescale 1ns/1ps
module inactive_hold #(
	parameter int unsigned SHORT_CYC = 200,
	parameter int unsigned LONG_CYC = 200000
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic start,
	input wire logic long_sel,
	// result
	output logic busy
);
	import mode_cfg_pkg::*;

	logic [CNT_W-1:0] left_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= '0;
			busy <= 1'b0;
		end else if (start) begin
			left_r <= long_sel ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);
			busy <= 1'b1;
		end else if (left_r != '0) begin
			left_r <= left_r - 1'b1;
			busy <= (left_r != CNT_W'(1));
		end else begin
			busy <= 1'b0;
		end
	end

endmodule : inactive_hold

// File: hdl/mode_cfg_top.sv
// Purpose: static mode configuration of a fieldbus slave, APB registers
// Assumes: single pclk domain; event and request inputs come from pclk logic
// Notes: mode register is writable only while offline
`timescale 1ns/1ps

module mode_cfg_top #(
	parameter int unsigned RELEASE_LONG = mode_cfg_pkg::RELEASE_LONG_CYC,
	parameter int unsigned TICK_SHORT = mode_cfg_pkg::TICK_SHORT_CYC,
	parameter int unsigned TICK_LONG = mode_cfg_pkg::TICK_LONG_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mode_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device side requests and events
	input wire logic sync_request,
	input wire logic freeze_request,
	input wire logic ext_event,
	// mode outputs
	output logic sync_mode_active,
	output logic freeze_mode_active,
	output logic cyclic_slave_protocol_enable,
	output logic protocol_service_access_points,
	output logic watchdog_test_active,
	output logic device_online,
	// interrupt pin
	output logic irq_pin
);
	import mode_cfg_pkg::*;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, OFS_MODE) || hit(a, OFS_CTRL) ||
			hit(a, OFS_STATE) || hit(a, OFS_EVT) ||
			hit(a, OFS_MASK) || hit(a, OFS_WD_LIMIT) ||
			hit(a, OFS_WD_COUNT);
	endfunction : mapped

	mode_cfg_s cfg_r;
	link_state_e state_r;
	logic [EVT_N-1:0] evt_r;
	logic [EVT_N-1:0] mask_r;
	logic [EVT_N-1:0] evt_set;
	logic [15:0] wd_limit_r;
	logic [15:0] wd_count_r;
	logic wd_run_r;
	logic tick;
	logic hold_busy;
	logic setup_ph;
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic mode_locked;
	logic [31:0] rd_mux;
	logic [15:0] mode_word;
	logic ctrl_wr;
	logic irq_level;

	assign setup_ph = psel && !penable;
	assign access_done = psel && penable && pready;
	assign wr_done = access_done && pwrite;
	assign rd_done = access_done && !pwrite;
	assign mode_locked = (state_r != ST_OFFLINE);
	assign ctrl_wr = wr_done && hit(paddr, OFS_CTRL);

	// ----------------------------------------------------------------
	// ready timing
	// ----------------------------------------------------------------
	// setup edge loads the read data; normal ready follows one cycle later,
	// early ready is raised on that same setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (setup_ph) begin
			pready <= cfg_r.early_ready;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
		end else begin
			pready <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			// writes to a locked mode register are refused, not stored
			pslverr <= !mapped(paddr) ||
				(pwrite && hit(paddr, OFS_MODE) && mode_locked);
		end else if (access_done) begin
			pslverr <= 1'b0;
		end
	end

	always_comb begin
		mode_word = '0;
		mode_word[POS_POL] = cfg_r.interrupt_polarity_select;
		mode_word[POS_EARLY] = cfg_r.early_ready;
		mode_word[POS_SYNC] = cfg_r.sync_supported;
		mode_word[POS_FREEZE] = cfg_r.freeze_supported;
		mode_word[POS_PROTO] = cfg_r.cyclic_slave_protocol_enable;
		mode_word[POS_REL_TB] = cfg_r.interrupt_release_timebase;
		mode_word[POS_TICK_TB] = cfg_r.tick_timebase;
		mode_word[POS_WATCHDOG_TEST_SELECT] = cfg_r.watchdog_test_select;
		rd_mux = '0;
		if (hit(paddr, OFS_MODE)) begin
			rd_mux = {16'h0000, mode_word};
		end else if (hit(paddr, OFS_STATE)) begin
			rd_mux = {29'h0, hold_busy, irq_level, !mode_locked};
		end else if (hit(paddr, OFS_EVT)) begin
			rd_mux = {29'h0, evt_r};
		end else if (hit(paddr, OFS_MASK)) begin
			rd_mux = {29'h0, mask_r};
		end else if (hit(paddr, OFS_WD_LIMIT)) begin
			rd_mux = {16'h0000, wd_limit_r};
		end else if (hit(paddr, OFS_WD_COUNT)) begin
			rd_mux = {16'h0000, wd_count_r};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup_ph && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// mode, mask and watchdog limit registers
	// ----------------------------------------------------------------
	// only the offline state accepts new mode settings, so the mode never
	// changes under a running protocol; mask and limit take writes in any state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= mode_cfg_s'(MODE_RESET[POS_WATCHDOG_TEST_SELECT:POS_POL]);
		end else if (wr_done && hit(paddr, OFS_MODE) && !mode_locked) begin
			cfg_r <= mode_cfg_s'(pwdata[POS_WATCHDOG_TEST_SELECT:POS_POL]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= MASK_RESET;
		end else if (wr_done && hit(paddr, OFS_MASK)) begin
			mask_r <= pwdata[EVT_N-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_limit_r <= WD_LIMIT_RESET;
		end else if (wr_done && hit(paddr, OFS_WD_LIMIT)) begin
			wd_limit_r <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// offline / online state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_OFFLINE;
		end else begin
			unique case (state_r)
				ST_OFFLINE: begin
					if (ctrl_wr && pwdata[POS_START]) begin
						state_r <= ST_ONLINE;
					end
				end
				ST_ONLINE: begin
					if (ctrl_wr && pwdata[POS_GO_OFFLINE]) begin
						state_r <= ST_OFFLINE;
					end
				end
				default: state_r <= ST_OFFLINE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// mode outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_mode_active <= 1'b0;
			freeze_mode_active <= 1'b0;
		end else begin
			sync_mode_active <= sync_request && cfg_r.sync_supported;
			freeze_mode_active <= freeze_request &&
				cfg_r.freeze_supported;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyclic_slave_protocol_enable <= 1'b0;
			protocol_service_access_points <= 1'b0;
			device_online <= 1'b0;
		end else begin
			cyclic_slave_protocol_enable <=
				cfg_r.cyclic_slave_protocol_enable;
			protocol_service_access_points <=
				cfg_r.cyclic_slave_protocol_enable && mode_locked;
			device_online <= mode_locked;
		end
	end

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	// test mode counts every pclk instead of every tick, so a short limit
	// expires within microseconds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_run_r <= 1'b0;
			wd_count_r <= '0;
		end else if (ctrl_wr && pwdata[POS_START] && !mode_locked) begin
			wd_run_r <= 1'b1;
			wd_count_r <= '0;
		end else if (!mode_locked) begin
			wd_run_r <= 1'b0;
			wd_count_r <= '0;
		end else if (ctrl_wr && (pwdata[POS_WD_KICK] || pwdata[POS_START])) begin
			wd_run_r <= 1'b1;
			wd_count_r <= '0;
		end else if (wd_run_r && (cfg_r.watchdog_test_select || tick)) begin
			if (wd_count_r >= wd_limit_r) begin
				wd_run_r <= 1'b0;
			end else begin
				wd_count_r <= wd_count_r + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_test_active <= 1'b0;
		end else begin
			watchdog_test_active <= cfg_r.watchdog_test_select;
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	assign evt_set[EVT_TICK] = tick;
	assign evt_set[EVT_WD] = wd_run_r && (wd_count_r >= wd_limit_r) &&
		(cfg_r.watchdog_test_select || tick);
	assign evt_set[EVT_EXT] = ext_event;

	// a set in the cycle of a clearing read wins over the clear; only bits
	// latched into the read data are cleared, so no event is lost in between
	genvar gi;
	generate
		for (gi = 0; gi < EVT_N; gi++) begin : g_evt
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					evt_r[gi] <= 1'b0;
				end else if (evt_set[gi]) begin
					evt_r[gi] <= 1'b1;
				end else if (rd_done && hit(paddr, OFS_EVT) && prdata[gi]) begin
					evt_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	tick_divider #(
		.SHORT_CYC(TICK_SHORT),
		.LONG_CYC(TICK_LONG)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.long_sel(cfg_r.tick_timebase),
		.tick(tick)
	);

	inactive_hold #(
		.SHORT_CYC(RELEASE_SHORT_CYC),
		.LONG_CYC(RELEASE_LONG)
	) u_hold (
		.pclk(pclk),
		.presetn(presetn),
		.start(ctrl_wr && pwdata[POS_RELEASE]),
		.long_sel(cfg_r.interrupt_release_timebase),
		.busy(hold_busy)
	);

	assign irq_level = |(evt_r & mask_r);

	// the release write itself also forces the pin inactive in its cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin <= 1'b1;
		end else if (hold_busy || (ctrl_wr && pwdata[POS_RELEASE])) begin
			irq_pin <= !cfg_r.interrupt_polarity_select;
		end else begin
			irq_pin <= irq_level ~^ cfg_r.interrupt_polarity_select;
		end
	end

endmodule : mode_cfg_top

// File: test/host_events.sv
// Purpose: host side event source feeding the device request inputs
// Assumes: bench commands change just after a rising pclk edge
// Notes: the event pulse lasts one cycle however long fire is held
`timescale 1ns/1ps
module host_events (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench commands
	input wire logic want_sync,
	input wire logic want_freeze,
	input wire logic fire,
	// towards the device
	output logic sync_request,
	output logic freeze_request,
	output logic ext_event
);
	logic fire_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_request <= 1'h0;
			freeze_request <= 1'h0;
		end else begin
			sync_request <= want_sync;
			freeze_request <= want_freeze;
		end
	end

	// edge detect so a held command cannot flood the event bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fire_r <= 1'h0;
			ext_event <= 1'h0;
		end else begin
			fire_r <= fire;
			ext_event <= fire && !fire_r;
		end
	end
endmodule : host_events

// File: test/mode_cfg_sva.sv
// Purpose: port assertions of the mode configuration block
// Assumes: one pclk domain; mode and mask shadowed from apb writes
// Notes: windows leave a cycle or two of slack for output registers
`timescale 1ns/1ps
module mode_cfg_sva #(
	parameter int unsigned RELEASE_LONG = 200000
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mode_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// device side
	input wire logic sync_request,
	input wire logic freeze_request,
	input wire logic ext_event,
	input wire logic sync_mode_active,
	input wire logic freeze_mode_active,
	input wire logic cyclic_slave_protocol_enable,
	input wire logic protocol_service_access_points,
	input wire logic watchdog_test_active,
	input wire logic device_online,
	input wire logic irq_pin
);
	import mode_cfg_pkg::*;
	logic [15:0] mode_sh;
	logic [2:0] mask_sh;
	logic done_w;
	int unsigned hold_n;
	int unsigned hold_cnt;
	int unsigned hold_len;

	assign done_w = psel && penable && pready && pwrite && !pslverr;
	assign hold_n = mode_sh[POS_REL_TB] ? RELEASE_LONG : RELEASE_SHORT_CYC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_sh <= 16'h0000;
		else if (done_w && paddr == OFS_MODE)
			mode_sh <= pwdata[15:0] & 16'h0FF0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_sh <= 3'h0;
		else if (done_w && paddr == OFS_MASK)
			mask_sh <= pwdata[2:0];
	end

	// a release restarts the quiet window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= 0;
			hold_len <= 0;
		end else if (done_w && paddr == OFS_CTRL && pwdata[POS_RELEASE]) begin
			hold_cnt <= hold_n;
			hold_len <= hold_n;
		end else if (hold_cnt != 0)
			hold_cnt <= hold_cnt - 1;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence slow_s;
		!pready ##1 pready;
	endsequence

	a_ready_normal:
	assert property (setup_s ##0 !mode_sh[POS_EARLY] |=> slow_s)
		else $error("ready not two cycles after setup");
	a_ready_early:
	assert property (setup_s ##0 mode_sh[POS_EARLY] |=> pready)
		else $error("ready not one cycle after setup");
	a_irq_idle:
	assert property (mask_sh == 0 && $past(mask_sh) == 0
		&& $past(mask_sh, 2) == 0 && $stable(mode_sh[POS_POL])
		&& $past(mode_sh[POS_POL], 2) == mode_sh[POS_POL]
		|-> irq_pin == !mode_sh[POS_POL])
		else $error("interrupt pin not at idle level");
	a_sync_gate:
	assert property (sync_mode_active
		== $past(sync_request && mode_sh[POS_SYNC]))
		else $error("sync mode output wrong");
	a_freeze_gate:
	assert property (freeze_mode_active
		== $past(freeze_request && mode_sh[POS_FREEZE]))
		else $error("freeze mode output wrong");
	a_proto_enable:
	assert property (cyclic_slave_protocol_enable == $past(mode_sh[POS_PROTO]))
		else $error("protocol enable wrong");
	a_points_gate:
	assert property (protocol_service_access_points
		|-> $past(mode_sh[POS_PROTO]) && device_online)
		else $error("access points without enable");
	a_hold_quiet:
	assert property (hold_cnt > 2 && hold_cnt + 1 < hold_len
		|-> irq_pin == !mode_sh[POS_POL])
		else $error("interrupt active during release hold");
	a_watchdog_test_select:
	assert property ($stable(mode_sh[POS_WATCHDOG_TEST_SELECT])
		|-> watchdog_test_active == mode_sh[POS_WATCHDOG_TEST_SELECT])
		else $error("watchdog test output wrong");
	a_online_lock:
	assert property (psel && penable && pready && pwrite
		&& paddr == OFS_MODE && device_online |-> pslverr)
		else $error("mode write while online not refused");
	a_unmapped_err:
	assert property (psel && penable && pready && paddr > OFS_WD_COUNT
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
endmodule : mode_cfg_sva

bind mode_cfg_top mode_cfg_sva #(.RELEASE_LONG(RELEASE_LONG)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sync_request(sync_request),
	.freeze_request(freeze_request), .ext_event(ext_event),
	.sync_mode_active(sync_mode_active),
	.freeze_mode_active(freeze_mode_active),
	.cyclic_slave_protocol_enable(cyclic_slave_protocol_enable),
	.protocol_service_access_points(protocol_service_access_points),
	.watchdog_test_active(watchdog_test_active),
	.device_online(device_online), .irq_pin(irq_pin));

// File: test/fieldbus_slave_mode_config_tb.sv
// Purpose: self-checking bench of the mode configuration block
// Assumes: long hold and tick counts shortened through the top parameters
// Notes: watchdog test mode is set once on purpose, then cleared
`timescale 1ns/1ps
module fieldbus_slave_mode_config_tb;
	import mode_cfg_pkg::*;
	localparam int unsigned REL_L = 50;
	localparam int unsigned TK_S = 20;
	localparam int unsigned TK_L = 60;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rq, mv;
	logic want_sync, want_freeze, fire, sync_request, freeze_request;
	logic ext_event, sync_mode_active, freeze_mode_active, device_online;
	logic cyclic_slave_protocol_enable, protocol_service_access_points;
	logic watchdog_test_active, irq_pin;
	int rn, cyc, t1, t2, nh, miscompares, checks_done;

	mode_cfg_top #(.RELEASE_LONG(REL_L), .TICK_SHORT(TK_S),
		.TICK_LONG(TK_L)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync_request(sync_request),
		.freeze_request(freeze_request), .ext_event(ext_event),
		.sync_mode_active(sync_mode_active),
		.freeze_mode_active(freeze_mode_active),
		.cyclic_slave_protocol_enable(cyclic_slave_protocol_enable),
		.protocol_service_access_points(protocol_service_access_points),
		.watchdog_test_active(watchdog_test_active),
		.device_online(device_online), .irq_pin(irq_pin));
	host_events u_host (.pclk(pclk), .presetn(presetn),
		.want_sync(want_sync), .want_freeze(want_freeze), .fire(fire),
		.sync_request(sync_request), .freeze_request(freeze_request),
		.ext_event(ext_event));

	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s exp %0h seen %0h", what, exp, seen);
		end
	endtask : check

	// one idle cycle between transfers keeps each signal single-driven
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		rn = 0;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			rn++;
		end while (pready !== 1'h1 && rn < 50);
		rq = prdata;
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		check("ready wait", rn < 50, 1'h1);
	endtask : xfer

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		xfer(1'h0, a, 32'h0);
	endtask : rd

	// waits for the pin to leave and then regain its active level
	task automatic rise(input logic act, output int t);
		int n;
		n = 0;
		while (irq_pin === act && n < 400) begin
			@(posedge pclk);
			n++;
		end
		while (irq_pin !== act && n < 400) begin
			@(posedge pclk);
			n++;
		end
		check("irq wait", n < 400, 1'h1);
		t = cyc;
	endtask : rise

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, fire, want_sync, want_freeze} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'h0;
		{cyc, miscompares, checks_done} = 96'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rd(OFS_MODE);
		check("mode reset", rq, 32'h0);
		check("normal ready", rn, 2);
		rd(OFS_MASK);
		check("mask reset", rq, 32'h0);
		rd(OFS_WD_LIMIT);
		check("limit reset", rq, 32'hFFFF);
		rd(8'h1C);
		check("unmapped", {rq[30:0], re}, 32'h1);
		wr(OFS_MODE, 32'h20);
		rd(OFS_MODE);
		check("mode readback", rq, 32'h20);
		check("early ready", rn, 1);
		want_sync <= 1'h1;
		want_freeze <= 1'h1;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_MODE, i ? 32'h1E0 : 32'h20);
			repeat (3) @(posedge pclk);
			check("sync", sync_mode_active, i);
			check("freeze", freeze_mode_active, i);
			check("protocol", cyclic_slave_protocol_enable, i);
		end
		wr(OFS_MODE, 32'h820);
		repeat (2) @(posedge pclk);
		check("watchdog_test_select on", watchdog_test_active, 1'h1);
		wr(OFS_MODE, 32'h120);
		repeat (2) @(posedge pclk);
		check("watchdog_test_select off", watchdog_test_active, 1'h0);
		wr(OFS_CTRL, 32'h1);
		repeat (2) @(posedge pclk);
		check("online", device_online, 1'h1);
		check("points on", protocol_service_access_points, 1'h1);
		wr(OFS_MODE, 32'h20);
		check("locked write", re, 1'h1);
		rd(OFS_MODE);
		check("mode kept", rq, 32'h120);
		wr(OFS_CTRL, 32'h4);
		repeat (2) @(posedge pclk);
		check("points off", protocol_service_access_points, 1'h0);
		for (int p = 0; p < 2; p++) begin
			mv = 32'h20 | (p << 4) | (p << 9) | (p << 10);
			nh = p ? REL_L : RELEASE_SHORT_CYC;
			wr(OFS_MASK, 32'h0);
			wr(OFS_MODE, mv);
			repeat (4) @(posedge pclk);
			check("idle level", irq_pin, !p);
			wr(OFS_MASK, 32'h1);
			rise(p, t1);
			check("active level", irq_pin, p);
			rd(OFS_EVT);
			rd(OFS_EVT);
			rise(p, t1);
			rd(OFS_EVT);
			rise(p, t2);
			check("tick period", t2 - t1, p ? TK_L : TK_S);
			wr(OFS_CTRL, 32'h2);
			t1 = cyc;
			rise(p, t2);
			check("hold span", t2 - t1 >= nh && t2 - t1 <= nh + 4, 1'h1);
		end
		fire <= 1'h1;
		@(posedge pclk);
		fire <= 1'h0;
		repeat (3) @(posedge pclk);
		rd(OFS_EVT);
		check("ext event", rq[EVT_EXT], 1'h1);
		rd(OFS_EVT);
		check("ext cleared", rq[EVT_EXT], 1'h0);
		// normal watchdog: limit 2 expires on the third long tick
		wr(OFS_WD_LIMIT, 32'h2);
		wr(OFS_CTRL, 32'h1);
		repeat (200) @(posedge pclk);
		rd(OFS_STATE);
		check("state online", rq[0], 1'h0);
		rd(OFS_WD_COUNT);
		check("wd count", rq, 32'h2);
		rd(OFS_EVT);
		check("wd expiry", rq[EVT_WD], 1'h1);
		wr(OFS_CTRL, 32'h4);
		conclude();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		conclude();
	end
endmodule : fieldbus_slave_mode_config_tb
